// [hw/tsw_map.svh]
`ifndef TSW_MAP_SVH
`define TSW_MAP_SVH

// Byte offsets on the register port
`define TSW_OFF_CHAN0_CTRL 8'h00
`define TSW_OFF_CHAN1_CTRL 8'h04
`define TSW_OFF_CHAN0_INIT 8'h08
`define TSW_OFF_CHAN1_INIT 8'h0c
`define TSW_OFF_CHAN0_COUNT 8'h10
`define TSW_OFF_CHAN1_COUNT 8'h14
`define TSW_OFF_FLAGS 8'h18
`define TSW_OFF_WD_CTRL 8'h1c

// Channel control fields
`define TSW_BIT_COUNT_ENABLE 0
`define TSW_BIT_INT_ENABLE 1

// Zero-count flag fields
`define TSW_BIT_CHAN0_FLAG 0
`define TSW_BIT_CHAN1_FLAG 1

// Watchdog control fields
`define TSW_BIT_WD_TEST_MODE 8
`define TSW_BIT_DEBUG_HOLD 9
`define TSW_BIT_WD_DIV_SELECT 10

// Reset values
`define TSW_RST_COUNT 32'h0000_0000
`define TSW_RST_FLAGS 2'h0
`define TSW_RST_WD_CTRL 32'h0000_0400

// Watchdog clock divider and counter shape
`define TSW_WD_DIV 256
`define TSW_WD_DIV_W 8
`define TSW_WD_CNT_W 20
`define TSW_WD_HALF_W 10

`endif

// [hw/tsw_pkg.sv]
package tsw_pkg;
    typedef logic [31:0] tsw_word_t;
    typedef logic [7:0] tsw_addr_t;
    typedef enum logic {
        TSW_WD_NORMAL,
        TSW_WD_SPLIT
    } tsw_wd_mode_t;
endpackage

// [hw/tsw_chan.sv]
`timescale 1ns/1ps
`include "tsw_map.svh"

module tsw_chan #(
    parameter int CNT_W = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic count_enable,
    input wire logic load_initial,
    input wire logic [CNT_W-1:0] initial_count,
    output logic [CNT_W-1:0] present_count,
    output logic zero_event
);
    logic [CNT_W-1:0] next_present_count;
    logic next_zero_event;

    always_comb begin
        next_present_count = present_count;
        next_zero_event = 1'b0;
        if (load_initial) begin
            // A new initial count aborts the running count
            next_present_count = initial_count;
        end else if (count_enable) begin
            if (present_count == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                next_present_count = initial_count;
                next_zero_event = 1'b1;
            end else if (present_count == '0) begin
                // Idle count after reset: start from the programmed value
                next_present_count = initial_count;
            end else begin
                next_present_count = present_count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            present_count <= '0;
            zero_event <= 1'b0;
        end else begin
            present_count <= next_present_count;
            zero_event <= next_zero_event;
        end
    end
endmodule

// [hw/tsw_top.sv]
// Notes on behaviour
// - Each channel count readable, 32-bit, resets zero
// - Channel-1 reaching zero sets flag bit 1
// - Channel-0 reaching zero sets flag bit 0
// - Writing one clears a zero-count flag
// - Flag raised only with interrupt enable set
// - Select bit 10 picks undivided or /256 clock
// - Watchdog clocked from crystal input
// - Test mode forces undivided watchdog clock
// - Debug acknowledge freezes watchdog unless overridden
// - Watchdog uses a 20-bit counter
// - Test mode splits counter into two 10-bit halves
// - Test mode half overflow raises watchdog interrupt
// - Count enable stops or starts counting
// - Counter reloads initial count at zero
`timescale 1ns/1ps
`include "tsw_map.svh"

module tsw_top #(
    parameter int CHANNELS = 2,
    parameter int CNT_W = 32
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic xtal_in,
    input wire logic debug_acknowledge_in,
    output logic [1:0] chan_irq,
    output logic wd_irq,
    output logic [19:0] wd_count
);
    // Channel control and initial count registers
    logic [CHANNELS-1:0] count_enable;
    logic [CHANNELS-1:0] int_enable;
    logic [CHANNELS-1:0] load_initial;
    logic [CNT_W-1:0] initial_count [CHANNELS];
    logic [CNT_W-1:0] present_count [CHANNELS];
    logic [CHANNELS-1:0] zero_event;
    logic [CHANNELS-1:0] next_count_enable;
    logic [CHANNELS-1:0] next_int_enable;
    logic [CHANNELS-1:0] next_load_initial;
    logic [CNT_W-1:0] next_initial_count [CHANNELS];

    // Flags and watchdog control
    logic [1:0] zero_count_flags;
    logic [1:0] next_zero_count_flags;
    logic wd_div_select;
    logic debug_hold_override;
    logic wd_test_mode;
    logic next_wd_div_select;
    logic next_debug_hold_override;
    logic next_wd_test_mode;

    // Read path
    logic [31:0] next_reg_rdata;

    // Pin synchronisers and watchdog counting
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    logic dbg_meta;
    logic dbg_sync;
    logic [`TSW_WD_DIV_W-1:0] wd_prescale;
    logic [`TSW_WD_DIV_W-1:0] next_wd_prescale;
    logic [`TSW_WD_CNT_W-1:0] next_wd_count;
    logic next_wd_irq;
    logic xtal_edge;
    logic wd_freeze;
    logic wd_advance;
    tsw_pkg::tsw_wd_mode_t wd_mode;

    function automatic logic is_addr(input tsw_pkg::tsw_addr_t a, input tsw_pkg::tsw_addr_t b);
        is_addr = (a == b);
    endfunction

    // Register writes
    always_comb begin
        next_count_enable = count_enable;
        next_int_enable = int_enable;
        next_load_initial = '0;
        next_wd_div_select = wd_div_select;
        next_debug_hold_override = debug_hold_override;
        next_wd_test_mode = wd_test_mode;
        for (int i = 0; i < CHANNELS; i++) begin
            next_initial_count[i] = initial_count[i];
        end
        if (reg_wr) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (is_addr(reg_addr, `TSW_OFF_CHAN0_CTRL + 8'(4 * i))) begin
                    next_count_enable[i] = reg_wdata[`TSW_BIT_COUNT_ENABLE];
                    next_int_enable[i] = reg_wdata[`TSW_BIT_INT_ENABLE];
                end
                if (is_addr(reg_addr, `TSW_OFF_CHAN0_INIT + 8'(4 * i))) begin
                    next_initial_count[i] = reg_wdata[CNT_W-1:0];
                    next_load_initial[i] = 1'b1;
                end
            end
            if (is_addr(reg_addr, `TSW_OFF_WD_CTRL)) begin
                next_wd_div_select = reg_wdata[`TSW_BIT_WD_DIV_SELECT];
                next_debug_hold_override = reg_wdata[`TSW_BIT_DEBUG_HOLD];
                next_wd_test_mode = reg_wdata[`TSW_BIT_WD_TEST_MODE];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_enable <= '0;
            int_enable <= '0;
            load_initial <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                initial_count[i] <= '0;
            end
            wd_div_select <= 1'(`TSW_RST_WD_CTRL >> `TSW_BIT_WD_DIV_SELECT);
            debug_hold_override <= 1'b0;
            wd_test_mode <= 1'b0;
        end else begin
            count_enable <= next_count_enable;
            int_enable <= next_int_enable;
            load_initial <= next_load_initial;
            for (int i = 0; i < CHANNELS; i++) begin
                initial_count[i] <= next_initial_count[i];
            end
            wd_div_select <= next_wd_div_select;
            debug_hold_override <= next_debug_hold_override;
            wd_test_mode <= next_wd_test_mode;
        end
    end

    // One counter per channel
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            tsw_chan #(
                .CNT_W(CNT_W)
            ) u_chan (
                .core_clk(core_clk),
                .nrst(nrst),
                .count_enable(count_enable[g]),
                .load_initial(load_initial[g]),
                .initial_count(initial_count[g]),
                .present_count(present_count[g]),
                .zero_event(zero_event[g])
            );
        end
    endgenerate

    // Zero-count flags; a set in the clearing cycle wins
    always_comb begin
        next_zero_count_flags = zero_count_flags;
        if (reg_wr && is_addr(reg_addr, `TSW_OFF_FLAGS)) begin
            next_zero_count_flags = zero_count_flags & ~reg_wdata[1:0];
        end
        if (zero_event[0] && int_enable[0]) begin
            next_zero_count_flags[`TSW_BIT_CHAN0_FLAG] = 1'b1;
        end
        if (zero_event[1] && int_enable[1]) begin
            next_zero_count_flags[`TSW_BIT_CHAN1_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            zero_count_flags <= `TSW_RST_FLAGS;
        end else begin
            zero_count_flags <= next_zero_count_flags;
        end
    end

    assign chan_irq = zero_count_flags;

    // Read data, one cycle after the strobe; counts are only exact while stopped
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `TSW_OFF_CHAN0_CTRL: next_reg_rdata = {30'h0, int_enable[0], count_enable[0]};
                `TSW_OFF_CHAN1_CTRL: next_reg_rdata = {30'h0, int_enable[1], count_enable[1]};
                `TSW_OFF_CHAN0_INIT: next_reg_rdata = initial_count[0];
                `TSW_OFF_CHAN1_INIT: next_reg_rdata = initial_count[1];
                `TSW_OFF_CHAN0_COUNT: next_reg_rdata = present_count[0];
                `TSW_OFF_CHAN1_COUNT: next_reg_rdata = present_count[1];
                `TSW_OFF_FLAGS: next_reg_rdata = {30'h0, zero_count_flags};
                `TSW_OFF_WD_CTRL: next_reg_rdata = {21'h0, wd_div_select,
                    debug_hold_override, wd_test_mode, 8'h00};
                default: next_reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Crystal and debug pins cross in through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
            dbg_meta <= 1'b0;
            dbg_sync <= 1'b0;
        end else begin
            xtal_meta <= xtal_in;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
            dbg_meta <= debug_acknowledge_in;
            dbg_sync <= dbg_meta;
        end
    end

    // Crystal must be below half of core_clk for edges to be seen
    assign xtal_edge = xtal_sync & ~xtal_prev;
    assign wd_freeze = dbg_sync & ~debug_hold_override;
    assign wd_mode = wd_test_mode ? tsw_pkg::TSW_WD_SPLIT : tsw_pkg::TSW_WD_NORMAL;

    // Watchdog prescaler and 20-bit counter
    always_comb begin
        next_wd_prescale = wd_prescale;
        wd_advance = 1'b0;
        if (xtal_edge && !wd_freeze) begin
            next_wd_prescale = wd_prescale + `TSW_WD_DIV_W'(1);
            if (!wd_div_select || wd_mode == tsw_pkg::TSW_WD_SPLIT) begin
                wd_advance = 1'b1;
            end else begin
                wd_advance = (wd_prescale == `TSW_WD_DIV_W'(`TSW_WD_DIV - 1));
            end
        end
    end

    always_comb begin
        next_wd_count = wd_count;
        next_wd_irq = 1'b0;
        if (wd_advance) begin
            case (wd_mode)
                tsw_pkg::TSW_WD_SPLIT: begin
                    // Halves run apart, carry does not ripple
                    next_wd_count[9:0] = wd_count[9:0] + 10'h001;
                    next_wd_count[19:10] = wd_count[19:10] + 10'h001;
                    next_wd_irq = (&wd_count[9:0]) | (&wd_count[19:10]);
                end
                tsw_pkg::TSW_WD_NORMAL: begin
                    next_wd_count = wd_count + 20'h00001;
                    next_wd_irq = &wd_count;
                end
                default: begin
                    next_wd_count = wd_count;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wd_prescale <= '0;
            wd_count <= '0;
            wd_irq <= 1'b0;
        end else begin
            wd_prescale <= next_wd_prescale;
            wd_count <= next_wd_count;
            wd_irq <= next_wd_irq;
        end
    end

    // Checks
    a_count_read_data: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_rd && reg_addr == `TSW_OFF_CHAN0_COUNT |=> reg_rdata == $past(present_count[0]))
        else $error("channel 0 count read mismatch");

    a_flag1_set: assert property (@(posedge core_clk) disable iff (!nrst)
        zero_event[1] && int_enable[1] |=> zero_count_flags[1])
        else $error("channel 1 flag not set");

    a_flag0_set: assert property (@(posedge core_clk) disable iff (!nrst)
        zero_event[0] && int_enable[0] |=> zero_count_flags[0])
        else $error("channel 0 flag not set");

    a_flag_w1c: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_wr && reg_addr == `TSW_OFF_FLAGS && reg_wdata[0] && !zero_event[0]
        |=> !zero_count_flags[0])
        else $error("flag 0 not cleared by one");

    a_flag_needs_ie: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(zero_count_flags[1]) |-> $past(zero_event[1] && int_enable[1]))
        else $error("flag 1 rose without enable");

    a_flag_zero_keep: assert property (@(posedge core_clk) disable iff (!nrst)
        reg_wr && reg_addr == `TSW_OFF_FLAGS && !reg_wdata[0] && zero_count_flags[0]
        |=> zero_count_flags[0])
        else $error("flag 0 lost on zero write");

    a_chan_stopped: assert property (@(posedge core_clk) disable iff (!nrst)
        !count_enable[0] && !load_initial[0] |=> $stable(present_count[0]))
        else $error("channel 0 moved while stopped");

    a_chan_reload: assert property (@(posedge core_clk) disable iff (!nrst)
        count_enable[0] && !load_initial[0] && present_count[0] == 32'h0000_0001
        |=> zero_event[0] && present_count[0] == $past(initial_count[0]))
        else $error("channel 0 reload missing");

    a_wd_div_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        xtal_edge && wd_div_select && !wd_test_mode && wd_prescale != 8'hff
        |=> $stable(wd_count))
        else $error("divided watchdog advanced early");

    a_wd_test_clk: assert property (@(posedge core_clk) disable iff (!nrst)
        xtal_edge && wd_test_mode && !wd_freeze |=> wd_count != $past(wd_count))
        else $error("test mode watchdog not undivided");

    a_wd_freeze: assert property (@(posedge core_clk) disable iff (!nrst)
        dbg_sync && !debug_hold_override |=> $stable(wd_count))
        else $error("watchdog ran during debug");

    a_wd_split_ovf: assert property (@(posedge core_clk) disable iff (!nrst)
        wd_advance && wd_test_mode && wd_count[9:0] == 10'h3ff
        |=> wd_irq && wd_count[9:0] == 10'h000
            && wd_count[19:10] == $past(wd_count[19:10]) + 10'h001)
        else $error("split watchdog overflow wrong");
endmodule

// [dv/tsw_top_tb.sv]
`timescale 1ns/1ps
`include "tsw_map.svh"

`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); \
    end \
end

module tsw_top_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    tsw_pkg::tsw_addr_t reg_addr = 8'h00;
    tsw_pkg::tsw_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    tsw_pkg::tsw_word_t reg_rdata;
    logic xtal_in = 1'b0;
    logic debug_acknowledge_in = 1'b0;
    logic [1:0] chan_irq;
    logic wd_irq;
    logic [19:0] wd_count;
    int fails = 0;
    int total_checks = 0;
    int irq_cnt = 0;

    always #5 core_clk = ~core_clk;

    // Pulses last one cycle, so count them on every edge
    always @(posedge core_clk) begin
        if (wd_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    tsw_top u_dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .xtal_in(xtal_in),
        .debug_acknowledge_in(debug_acknowledge_in),
        .chan_irq(chan_irq),
        .wd_irq(wd_irq),
        .wd_count(wd_count)
    );

    task automatic results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input tsw_pkg::tsw_addr_t a, input tsw_pkg::tsw_word_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input tsw_pkg::tsw_addr_t a, output tsw_pkg::tsw_word_t d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input tsw_pkg::tsw_addr_t a, input tsw_pkg::tsw_word_t e);
        tsw_pkg::tsw_word_t d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // High 3 and low 4 cycles, well below the sampling limit
    task automatic xedges(input int n);
        repeat (n) begin
            @(posedge core_clk);
            xtal_in <= 1'b1;
            repeat (3) @(posedge core_clk);
            xtal_in <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset;
        `CHK(wd_count, 20'h0)
        `CHK(chan_irq, 2'b00)
        rd_chk(`TSW_OFF_CHAN0_COUNT, `TSW_RST_COUNT);
        rd_chk(`TSW_OFF_CHAN1_COUNT, `TSW_RST_COUNT);
        rd_chk(`TSW_OFF_FLAGS, 32'h0);
        rd_chk(`TSW_OFF_WD_CTRL, `TSW_RST_WD_CTRL);
        rd_chk(8'h20, 32'h0);
        wr(`TSW_OFF_WD_CTRL, 32'hffff_ffff);
        rd_chk(`TSW_OFF_WD_CTRL, 32'h0000_0700);
        wr(`TSW_OFF_WD_CTRL, `TSW_RST_WD_CTRL);
        $display("t_reset done");
    endtask

    task automatic t_count;
        tsw_pkg::tsw_word_t d;
        tsw_pkg::tsw_word_t d2;
        wr(`TSW_OFF_CHAN0_INIT, 32'h7);
        repeat (3) @(posedge core_clk);
        rd_chk(`TSW_OFF_CHAN0_COUNT, 32'h7);
        wr(`TSW_OFF_CHAN0_COUNT, 32'hffff_ffff);
        rd_chk(`TSW_OFF_CHAN0_COUNT, 32'h7);
        wr(`TSW_OFF_CHAN0_INIT, 32'h64);
        wr(`TSW_OFF_CHAN0_CTRL, 32'h1);
        repeat (5) @(posedge core_clk);
        // Seven enabled edges: one decrement each
        wr(`TSW_OFF_CHAN0_CTRL, 32'h0);
        rd(`TSW_OFF_CHAN0_COUNT, d);
        `CHK(d, 32'h0000_005d)
        repeat (10) @(posedge core_clk);
        rd(`TSW_OFF_CHAN0_COUNT, d2);
        `CHK(d2, d)
        $display("t_count done");
    endtask

    task automatic t_noint;
        tsw_pkg::tsw_word_t d;
        wr(`TSW_OFF_CHAN0_INIT, 32'h2);
        wr(`TSW_OFF_CHAN0_CTRL, 32'h1);
        repeat (30) @(posedge core_clk);
        // Thirty-two enabled edges from 2 end on a reload
        wr(`TSW_OFF_CHAN0_CTRL, 32'h0);
        rd_chk(`TSW_OFF_FLAGS, 32'h0);
        `CHK(chan_irq, 2'b00)
        rd(`TSW_OFF_CHAN0_COUNT, d);
        `CHK(d, 32'h0000_0002)
        $display("t_noint done");
    endtask

    task automatic t_flag(input int ch);
        tsw_pkg::tsw_word_t m;
        int i;
        m = 32'h1 << ch;
        wr(`TSW_OFF_CHAN0_INIT + 8'(4 * ch), 32'h3);
        wr(`TSW_OFF_CHAN0_CTRL + 8'(4 * ch), 32'h3);
        i = 0;
        while (chan_irq[ch] !== 1'b1 && i < 100) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 100) begin
            fails++;
            $display("[ERR] %0t zero flag never rose", $time);
            results();
        end
        wr(`TSW_OFF_CHAN0_CTRL + 8'(4 * ch), 32'h0);
        rd_chk(`TSW_OFF_FLAGS, m);
        wr(`TSW_OFF_FLAGS, ~m);
        rd_chk(`TSW_OFF_FLAGS, m);
        wr(`TSW_OFF_FLAGS, m);
        rd_chk(`TSW_OFF_FLAGS, 32'h0);
        `CHK(chan_irq, 2'b00)
        $display("t_flag %0d done", ch);
    endtask

    task automatic t_wd;
        logic [19:0] w0;
        int n;
        int irq0;
        wr(`TSW_OFF_WD_CTRL, 32'h0);
        xedges(0);
        w0 = wd_count;
        xedges(4);
        `CHK(wd_count, w0 + 20'h4)
        @(posedge core_clk);
        debug_acknowledge_in <= 1'b1;
        xedges(0);
        w0 = wd_count;
        xedges(4);
        `CHK(wd_count, w0)
        wr(`TSW_OFF_WD_CTRL, 32'h200);
        w0 = wd_count;
        xedges(4);
        `CHK(wd_count, w0 + 20'h4)
        @(posedge core_clk);
        debug_acknowledge_in <= 1'b0;
        wr(`TSW_OFF_WD_CTRL, 32'h400);
        xedges(0);
        w0 = wd_count;
        xedges(`TSW_WD_DIV);
        `CHK(wd_count, w0 + 20'h1)
        wr(`TSW_OFF_WD_CTRL, 32'h500);
        w0 = wd_count;
        xedges(4);
        `CHK(wd_count, {w0[19:10] + 10'h4, w0[9:0] + 10'h4})
        // The half nearer to its top wraps first
        w0 = wd_count;
        n = 1024 - ((w0[9:0] > w0[19:10]) ? int'(w0[9:0]) : int'(w0[19:10]));
        irq0 = irq_cnt;
        xedges(n - 1);
        `CHK(irq_cnt, irq0)
        xedges(1);
        `CHK(irq_cnt, irq0 + 1)
        $display("t_wd done");
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_count();
        t_noint();
        t_flag(0);
        t_flag(1);
        t_wd();
        results();
    end
endmodule
